// >>> hw/prps_pkg.sv
// Purpose: constants and types for the private radio packet sequencer
// Assumes: 200 MHz core clock, one clock domain
// Notes:   control bits arrive as plain ports, no register bus
//
// Summary of operation
// - timeout enable low active, length in microseconds
// - variant select only in second chip mode
// - ack enable makes transmitter turn around
// - turnaround equals wait plus phy start time
// - ack payload option sends transmit buffer packet
// - interrupt with post phase; no phy access then
// - top address byte used only at five bytes
// - no transmit start while tx ready low; ack transmit does not check it
// - no packet stored while rx ready low
package prps_pkg;
    localparam int unsigned CLK_MHZ       = 200;
    localparam int unsigned US_CYCLES     = CLK_MHZ;
    localparam logic [1:0]  CHIP_MODE_TWO = 2'h3; // second compatible mode
    localparam logic [1:0]  ADDR_LEN_FIVE = 2'h3; // five byte address
    localparam logic [1:0]  ADDR_LEN_FOUR = 2'h2;
    localparam logic [7:0]  US_MAX        = 8'(US_CYCLES - 1);
    localparam int unsigned POST_US       = 4;    // post phase length

    typedef enum logic [3:0] {
        PRPS_IDLE, PRPS_TX, PRPS_TURN_TX, PRPS_RX, PRPS_TURN_RX,
        PRPS_ACK_TX, PRPS_ACK_RX, PRPS_POST, PRPS_DONE
    } prps_state_e;

    typedef struct packed {
        logic        dir_rx;          // 0 transmit, 1 receive
        logic        enhanced;
        logic        auto_turnaround_mode;
        logic [1:0]  chip_mode;
        logic        variant_sel;     // control bit 7
        logic        ack_receive_enable;
        logic        ack_payload_en;
        logic        rx_timeout_dis;  // active low enable
        logic [15:0] rx_wait_us;
        logic [15:0] turnaround_wait;
        logic [15:0] phy_switch_us;
        logic [1:0]  addr_len;
    } prps_cfg_s;

    typedef struct packed {
        logic        busy;
        logic        tx_active;
        logic        rx_active;
        logic        post_phase;
        logic        timed_out;
        logic        handshake_variant_one;
        logic        ack_with_payload;
    } prps_stat_s;
endpackage

// >>> hw/prps_sequencer.sv
// Purpose: sequencing of transmit, receive, turnaround and post phases
// Assumes: phy gives done pulses; inputs synchronous to i_core_clk
// Notes:   o_irq_pulse coincides with the start of the post phase
`timescale 1ns/1ps
module prps_sequencer
#(
    parameter int unsigned ADDR_W = 40
)
(
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rstn,
    input  wire prps_pkg::prps_cfg_s   i_cfg,
    input  wire logic                  i_tx_ram_ready,
    input  wire logic                  i_rx_ram_ready,
    input  wire logic [ADDR_W-1:0]     i_peer_addr,
    input  wire logic [ADDR_W-1:0]     i_rx_addr,
    input  wire logic                  i_tx_done,
    input  wire logic                  i_rx_pkt,
    output logic                       o_phy_tx_en,
    output logic                       o_phy_rx_en,
    output logic                       o_addr_match,
    output logic                       o_store_en,
    output logic                       o_irq_pulse,
    output prps_pkg::prps_stat_s       o_stat
);
    import prps_pkg::*;

    // ------------------------------------------------------------
    // address compare
    // ------------------------------------------------------------
    function automatic logic addr_eq(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] b,
                                     input logic [1:0]        len);
        logic [ADDR_W-1:0] m;
        m = '1;
        if (len != ADDR_LEN_FIVE)
            m[ADDR_W-1 -: 8] = 8'h00;       // top byte dropped
        if (len != ADDR_LEN_FIVE && len != ADDR_LEN_FOUR)
            m[ADDR_W-9 -: 8] = 8'h00;
        addr_eq = ((a ^ b) & m) == '0;
    endfunction

    // ------------------------------------------------------------
    // state and counters
    // ------------------------------------------------------------
    prps_state_e state_reg, state_next;
    logic [7:0]  us_div_reg, us_div_next;
    logic [15:0] us_cnt_reg, us_cnt_next;
    logic        tout_reg, tout_next;
    logic        armed_tx_reg, armed_tx_next;
    logic        armed_rx_reg, armed_rx_next;
    logic        us_tick;
    logic        turn_time;
    logic        ack_tx;
    logic        match;

    assign us_tick   = (us_div_reg == US_MAX);
    // real turnaround is wait plus phy switch time
    assign turn_time = us_tick && (us_cnt_reg + 16'h0001 >=
                       i_cfg.turnaround_wait + i_cfg.phy_switch_us);
    // enhanced transmitter listens for ack when enabled, or always in auto turnaround mode
    assign ack_tx    = i_cfg.enhanced && i_cfg.ack_receive_enable;
    assign match     = addr_eq(i_rx_addr, i_peer_addr, i_cfg.addr_len);

    // next state; rearm needs the ready flag seen low first
    always_comb
    begin
        state_next    = state_reg;
        us_div_next   = us_tick ? 8'h00 : us_div_reg + 8'h01;
        us_cnt_next   = us_tick ? us_cnt_reg + 16'h0001 : us_cnt_reg;
        tout_next     = tout_reg;
        armed_tx_next = armed_tx_reg | ~i_tx_ram_ready;
        armed_rx_next = armed_rx_reg | ~i_rx_ram_ready;
        unique case (state_reg)
            PRPS_IDLE:
            begin
                us_div_next = 8'h00;
                us_cnt_next = 16'h0000;
                if (!i_cfg.dir_rx && i_tx_ram_ready && armed_tx_reg)
                begin
                    state_next    = PRPS_TX;
                    armed_tx_next = 1'b0;
                    tout_next     = 1'b0;
                end
                else if (i_cfg.dir_rx && i_rx_ram_ready && armed_rx_reg)
                begin
                    state_next    = PRPS_RX;
                    armed_rx_next = 1'b0;
                    tout_next     = 1'b0;
                end
            end
            PRPS_TX:
            begin
                us_cnt_next = 16'h0000;
                if (i_tx_done)
                    state_next = (ack_tx || i_cfg.auto_turnaround_mode)
                               ? PRPS_TURN_TX : PRPS_POST;
            end
            PRPS_TURN_TX:
                if (turn_time)
                begin
                    state_next  = PRPS_ACK_RX;
                    us_cnt_next = 16'h0000;
                end
            PRPS_RX, PRPS_ACK_RX:
            begin
                // timeout enabled when the disable bit is low
                if (i_rx_pkt && match)
                begin
                    us_cnt_next = 16'h0000;
                    if (state_reg == PRPS_RX &&
                        (i_cfg.auto_turnaround_mode ||
                         (i_cfg.enhanced && i_cfg.ack_payload_en)))
                        state_next = PRPS_TURN_RX;
                    else
                        state_next = PRPS_POST;
                end
                else if (!i_cfg.rx_timeout_dis && us_tick &&
                         us_cnt_reg + 16'h0001 >= i_cfg.rx_wait_us)
                begin
                    tout_next   = 1'b1;
                    us_cnt_next = 16'h0000;
                    state_next  = PRPS_POST;
                end
            end
            PRPS_TURN_RX:
                if (turn_time)
                    state_next = PRPS_ACK_TX;
            PRPS_ACK_TX:
            begin
                us_cnt_next = 16'h0000;
                if (i_tx_done)
                    state_next = PRPS_POST;
            end
            PRPS_POST:
                if (us_tick && us_cnt_reg + 16'h0001 >= 16'(POST_US))
                    state_next = PRPS_DONE;
            PRPS_DONE:
                state_next = PRPS_IDLE;
            default:
                state_next = PRPS_IDLE;
        endcase
        // each phase times from its own start; a free divider would
        // shorten the first microsecond by up to a whole tick
        if (state_next != state_reg)
        begin
            us_div_next = 8'h00;
            us_cnt_next = 16'h0000;
        end
    end

    // register stage; armed flags start set so first request is taken
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg    <= PRPS_IDLE;
            us_div_reg   <= 8'h00;
            us_cnt_reg   <= 16'h0000;
            tout_reg     <= 1'b0;
            armed_tx_reg <= 1'b1;
            armed_rx_reg <= 1'b1;
        end
        else
        begin
            state_reg    <= state_next;
            us_div_reg   <= us_div_next;
            us_cnt_reg   <= us_cnt_next;
            tout_reg     <= tout_next;
            armed_tx_reg <= armed_tx_next;
            armed_rx_reg <= armed_rx_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // irq coincides with the entry to the post phase
    assign o_irq_pulse = (state_reg != PRPS_POST) && (state_next == PRPS_POST);
    assign o_phy_tx_en = (state_reg == PRPS_TX) || (state_reg == PRPS_ACK_TX);
    assign o_phy_rx_en = (state_reg == PRPS_RX) || (state_reg == PRPS_ACK_RX);
    assign o_addr_match = o_phy_rx_en && match;
    // store only while the receive buffer ready flag is high
    assign o_store_en  = o_phy_rx_en && i_rx_pkt && match && i_rx_ram_ready;

    // status bundle; variant only meaningful in second chip mode
    always_comb
    begin
        o_stat.busy       = (state_reg != PRPS_IDLE);
        o_stat.tx_active  = o_phy_tx_en;
        o_stat.rx_active  = o_phy_rx_en;
        o_stat.post_phase = (state_reg == PRPS_POST);
        o_stat.timed_out  = tout_reg;
        o_stat.handshake_variant_one = i_cfg.enhanced &&
            (i_cfg.chip_mode == CHIP_MODE_TWO) && i_cfg.variant_sel;
        // ack carries the transmit buffer packet
        o_stat.ack_with_payload = (state_reg == PRPS_ACK_TX) &&
            i_cfg.enhanced && i_cfg.ack_payload_en;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // watched at the outputs, so a broken start decode still trips it
    a_tx_needs_ready: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (o_phy_tx_en && $past(state_reg) == PRPS_IDLE)
        |-> $past(i_tx_ram_ready))
        else $error("transmit started without ready");
    a_store_needs_ready: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        o_store_en |-> i_rx_ram_ready)
        else $error("store without rx ready");
    a_irq_post_start: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        o_irq_pulse |=> (state_reg == PRPS_POST))
        else $error("irq not with post phase");
    a_no_ack_turn: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (state_reg == PRPS_TX && i_tx_done && !ack_tx &&
         !i_cfg.auto_turnaround_mode) |=> (state_reg == PRPS_POST))
        else $error("turned around without ack enable");
    a_timeout_off: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        $rose(tout_reg) |-> !$past(i_cfg.rx_timeout_dis))
        else $error("timeout while disabled");
    a_rearm_guard: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (state_reg == PRPS_DONE && i_tx_ram_ready && !i_cfg.dir_rx &&
         !armed_tx_reg) |=> ##1 (state_reg == PRPS_IDLE))
        else $error("stale tx ready retriggered");
    a_turn_not_early: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (state_reg == PRPS_TURN_TX && state_next == PRPS_ACK_RX) |->
        (us_cnt_reg + 16'h0001 >= i_cfg.turnaround_wait + i_cfg.phy_switch_us))
        else $error("turnaround shorter than wait plus phy");
    a_variant_gate: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_cfg.chip_mode != CHIP_MODE_TWO) |-> !o_stat.handshake_variant_one)
        else $error("variant used outside second mode");
    a_addr_short: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_cfg.addr_len != ADDR_LEN_FIVE &&
         i_rx_addr[ADDR_W-9:0] == i_peer_addr[ADDR_W-9:0] &&
         (i_cfg.addr_len == ADDR_LEN_FOUR ||
          i_rx_addr[ADDR_W-17:0] == i_peer_addr[ADDR_W-17:0])) |-> match)
        else $error("top address byte used");
    a_payload_ack: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (state_reg == PRPS_RX && i_rx_pkt && match && i_cfg.enhanced &&
         i_cfg.ack_payload_en && !i_cfg.auto_turnaround_mode)
        |=> (state_reg == PRPS_TURN_RX))
        else $error("payload ack not started");
endmodule

// >>> tb/prps_peer_model.sv
// Purpose: peer radio and phy stand-in for the sequencer bench
// Assumes: a transmit completes a fixed latency after phy enable
// Notes:   address lines toggle to their inverse every cycle outside a packet
`timescale 1ns/1ps
module prps_peer_model
#(
    parameter int TX_LAT = 5
)
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_phy_tx_en,
    input  wire logic        i_pkt_req,
    input  wire logic [39:0] i_pkt_addr,
    output logic             o_tx_done,
    output logic             o_rx_pkt,
    output logic [39:0]      o_rx_addr
);
    int cnt;

    // airtime count; idle address toggles each cycle, so stale bits return every other cycle
    always_ff @(posedge i_core_clk or negedge i_rstn)
        if (!i_rstn)
        begin
            cnt       <= 0;
            o_tx_done <= 1'b0;
            o_rx_pkt  <= 1'b0;
            o_rx_addr <= '0;
        end
        else
        begin
            cnt       <= i_phy_tx_en ? cnt + 1 : 0;
            o_tx_done <= i_phy_tx_en && cnt == TX_LAT - 1;
            o_rx_pkt  <= i_pkt_req;
            o_rx_addr <= i_pkt_req ? i_pkt_addr : ~o_rx_addr;
        end
endmodule

// >>> tb/prps_sequencer_tb_top.sv
// Purpose: self-checking bench for the packet sequencer
// Assumes: peer model answers a transmit after TX_LAT cycles
// Notes:   one microsecond is US_CYCLES core cycles
`timescale 1ns/1ps
module prps_sequencer_tb_top;
    import prps_pkg::*;
    localparam int TX_LAT = 5;
    localparam int TURN   = 2 * US_CYCLES;
    logic        i_core_clk = 1'b0;
    logic        i_rstn     = 1'b0;
    prps_cfg_s   cfg        = '0;
    logic        txr        = 1'b0;
    logic        rxr        = 1'b0;
    logic        req        = 1'b0;
    logic [39:0] peer       = '0;
    logic [39:0] req_addr   = '0;
    logic [39:0] rx_addr;
    logic        tx_done, rx_pkt, tx_en, rx_en, amatch, store, irq;
    prps_stat_s  stat;
    int          miscompares = 0;
    int          n_tests     = 0;
    int          seed        = 32'h2b9e;
    int          n;
    logic [39:0] tries [3];

    always #2.5 i_core_clk = ~i_core_clk;

    prps_sequencer prps_sequencer_i (.i_core_clk(i_core_clk),
        .i_rstn(i_rstn), .i_cfg(cfg), .i_tx_ram_ready(txr),
        .i_rx_ram_ready(rxr), .i_peer_addr(peer), .i_rx_addr(rx_addr),
        .i_tx_done(tx_done), .i_rx_pkt(rx_pkt), .o_phy_tx_en(tx_en),
        .o_phy_rx_en(rx_en), .o_addr_match(amatch), .o_store_en(store),
        .o_irq_pulse(irq), .o_stat(stat));
    prps_peer_model #(.TX_LAT(TX_LAT)) prps_peer_model_i (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_phy_tx_en(tx_en),
        .i_pkt_req(req), .i_pkt_addr(req_addr), .o_tx_done(tx_done),
        .o_rx_pkt(rx_pkt), .o_rx_addr(rx_addr));

    // reference match: only the low bytes of the chosen width count
    function automatic logic exp_match(int len, logic [39:0] a);
        int nb;
        nb = (len == 3) ? 40 : (len == 2) ? 32 : 24;
        for (int i = 0; i < nb; i++)
            if (a[i] !== peer[i])
                return 1'b0;
        return 1'b1;
    endfunction

    function automatic logic pick(int sel);
        return (sel == 0) ? irq : (sel == 1) ? tx_en : rx_en;
    endfunction

    task automatic tally_and_finish;
        if (miscompares == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH %0t %s", $time, m);
            miscompares++;
        end
    endtask

    task automatic chk_n(input int got, input int lo, input int hi,
                         input string m);
        chk(got >= lo && got <= hi, 1'b1, m);
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic cyc(input int k);
        repeat (k) @(posedge i_core_clk);
        #1;
    endtask

    // bounded wait so a missing event cannot hang the run
    task automatic wait_on(input int sel, output int c);
        c = 0;
        while (pick(sel) !== 1'b1 && c < 2000)
        begin
            cyc(1);
            c++;
        end
    endtask

    task automatic send(input logic [39:0] a, input logic e);
        req      = 1'b1;
        req_addr = a;
        cyc(1);
        req = 1'b0;
        chk(store, e, "store enable");
        chk(amatch, e, "address match");
    endtask

    task automatic finish_op(input logic to);
        int c;
        wait_on(0, c);
        chk(irq, 1'b1, "no interrupt");
        cyc(1);
        if (to)
            chk(stat.timed_out, 1'b1, "timeout flag");
        c = 0;
        while (stat.post_phase === 1'b1 && c < 2000)
        begin
            cyc(1);
            c++;
        end
        chk_n(c, POST_US * US_CYCLES, POST_US * US_CYCLES,
              "post");
        cyc(2);
    endtask

    initial
    begin
        #(40000 * 5);
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        repeat (8) @(posedge i_core_clk);
        #1 i_rstn = 1'b1;
        cfg.addr_len        = ADDR_LEN_FIVE;
        cfg.rx_timeout_dis  = 1'b1;
        cfg.rx_wait_us      = 16'h0002;
        cfg.turnaround_wait = 16'h0001;
        cfg.phy_switch_us   = 16'h0001;
        cyc(3);
        chk(tx_en, 1'b0, "sent without ready");
        txr = 1'b1;
        cyc(1);
        chk(tx_en, 1'b1, "no transmit");
        chk(stat.tx_active, 1'b1, "tx status");
        finish_op(1'b0);
        chk(stat.busy, 1'b0, "held ready restarted");
        txr = 1'b0;
        cyc(1);
        txr = 1'b1;
        cyc(1);
        chk(tx_en, 1'b1, "rearmed ready lost");
        finish_op(1'b0);
        txr        = 1'b0;
        cfg.dir_rx = 1'b1;
        cyc(1);
        send(peer, 1'b0);
        for (int l = 1; l < 4; l++)
        begin
            cfg.addr_len = l[1:0];
            peer         = 40'({$random(seed), $random(seed)});
            tries[0]     = peer ^ 40'h00ff000000;
            tries[1]     = peer ^ 40'hff00000000;
            tries[2]     = peer;
            rxr          = 1'b1;
            cyc(1);
            chk(rx_en, 1'b1, "no receive");
            chk(stat.rx_active, 1'b1, "rx status");
            for (int t = 0; t < 3; t++)
            begin
                send(tries[t], exp_match(l, tries[t]));
                if (exp_match(l, tries[t]))
                    break;
                // let an edge pass so req is not lowered and raised at once
                cyc(1);
            end
            finish_op(1'b0);
            rxr = 1'b0;
            cyc(1);
        end
        cfg.rx_timeout_dis = 1'b0;
        rxr                = 1'b1;
        wait_on(0, n);
        chk_n(n, TURN - 1, TURN + 2, "timeout length");
        finish_op(1'b1);
        rxr                    = 1'b0;
        cfg.rx_timeout_dis     = 1'b1;
        cfg.dir_rx             = 1'b0;
        cfg.enhanced           = 1'b1;
        cfg.ack_receive_enable = 1'b1;
        cyc(1);
        txr = 1'b1;
        rxr = 1'b1;
        wait_on(2, n);
        chk_n(n, TX_LAT + TURN - 2, TX_LAT + TURN + 4, "turn");
        send(peer, 1'b1);
        finish_op(1'b0);
        txr = 1'b0;
        rxr = 1'b0;
        cfg.dir_rx         = 1'b1;
        cfg.ack_payload_en = 1'b1;
        cyc(1);
        rxr = 1'b1;
        cyc(1);
        send(peer, 1'b1);
        wait_on(1, n);
        chk_n(n, TURN - 2, TURN + 3, "ack turn");
        chk(stat.ack_with_payload, 1'b1, "payload ack");
        finish_op(1'b0);
        for (int k = 0; k < 8; k++)
        begin
            cfg.chip_mode   = k[1:0];
            cfg.variant_sel = k[2];
            cyc(1);
            chk(stat.handshake_variant_one,
                k[1:0] == CHIP_MODE_TWO && k[2], "variant");
        end
        // auto turnaround receiver answers with a plain response, no payload ack
        rxr                      = 1'b0;
        cfg.enhanced             = 1'b0;
        cfg.ack_payload_en       = 1'b0;
        cfg.auto_turnaround_mode = 1'b1;
        cyc(1);
        rxr = 1'b1;
        cyc(1);
        send(peer, 1'b1);
        wait_on(1, n);
        chk_n(n, TURN - 2, TURN + 3, "auto turn");
        chk(stat.ack_with_payload, 1'b0, "plain response");
        finish_op(1'b0);
        tally_and_finish();
    end
endmodule
